// file: verif/test_alu_flags_and_data_addressing.sv
// Self-checking APB bench for the flag and data addressing core
`timescale 1ns/1ps
`default_nettype none
module test_alu_flags_and_data_addressing;
  import alu_addr_pkg::*;
  logic pclk; // Core clock
  logic presetn; // Reset, active low
  logic psel, penable, pwrite; // APB request
  logic [7:0] paddr; // APB byte address
  logic [31:0] pwdata, prdata; // APB data
  logic pready, pslverr; // APB answer
  int bad_count, compares, cycles; // Tallies and hang guard
  logic [31:0] rv; // Last read data
  logic ev; // Last error bit

  alu_addr_core #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask

  // One APB transfer; answer taken at the rising edge where pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so no strobe is driven twice in one step
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task chr(input string n, input logic [7:0] a, input logic [31:0] x,
    input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(n, rv & m, x);
  endtask

  // Launch a command word
  task ex(input logic [3:0] op, input logic d, input logic a, input logic [11:0] dst,
    input logic [11:0] src);
    wr(OFS_CMD, {op, d, a, 2'b00, dst, src});
  endtask

  // ALU op on an unmodelled file byte, answer lands in working
  task alu(input logic [3:0] op, input logic [7:0] f, input logic [7:0] w,
    input logic [7:0] fl, input logic [7:0] xr, input logic [7:0] xf);
    wr(OFS_FLAGS, {24'h0, fl});
    wr(OFS_WORK, {24'h0, w});
    wr(OFS_OPERAND, {24'h0, f});
    ex(op, 1'b0, 1'b0, 12'h000, 12'h010);
    chr("working", OFS_WORK, {24'h0, xr});
    chr("flags", OFS_FLAGS, {24'h0, xf});
  endtask

  task adr(input logic a, input logic [7:0] low, input logic [11:0] x);
    ex(OP_MOVF, 1'b0, a, 12'h000, {4'h0, low});
    chr("src addr", OFS_ADDR, {20'h0, x}, 32'h00000fff);
  endtask

  // Store through an indirect operand; flags must stay put
  task ind(input logic [7:0] pr, input logic [11:0] p0, input logic [7:0] low,
    input logic [11:0] xa, input logic [11:0] xp);
    wr(pr, {20'h0, p0});
    wr(OFS_FLAGS, 32'h1f);
    ex(OP_MOVE_FROM_WORKING_INSTR, 1'b1, 1'b0, 12'h000, {4'h0, low});
    chr("ind addr", OFS_ADDR, {20'h0, xa}, 32'h00000fff);
    chr("pointer", pr, {20'h0, xp});
    chr("flags", OFS_FLAGS, 32'h1f);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chr("flags reset", OFS_FLAGS, 32'h0);
    wr(OFS_FLAGS, 32'hff);
    chr("flags top", OFS_FLAGS, 32'h1f);
    $display("test register done");
    alu(OP_ADD, 8'h08, 8'h08, 8'h00, 8'h10, 8'h02);
    alu(OP_ADD, 8'h7f, 8'h01, 8'h00, 8'h80, 8'h1a);
    alu(OP_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 8'h07);
    alu(OP_SUB, 8'h05, 8'h05, 8'h00, 8'h00, 8'h07);
    alu(OP_SUB, 8'h00, 8'h01, 8'h1f, 8'hff, 8'h10);
    alu(OP_SUB, 8'h80, 8'h01, 8'h00, 8'h7f, 8'h09);
    alu(OP_RR, 8'h19, 8'h00, 8'h08, 8'h0c, 8'h0b);
    alu(OP_RL, 8'h81, 8'h00, 8'h00, 8'h02, 8'h01);
    alu(OP_RL, 8'h40, 8'h00, 8'h01, 8'h81, 8'h10);
    $display("test alu done");
    wr(OFS_FLAGS, 32'h13);
    ex(OP_CLR, 1'b1, 1'b0, 12'h000, 12'h0d8);
    chr("clr flags", OFS_FLAGS, 32'h17);
    wr(OFS_FLAGS, 32'h03);
    wr(OFS_WORK, 32'h1c);
    ex(OP_AND, 1'b1, 1'b0, 12'h000, 12'h0d8);
    chr("and flags", OFS_FLAGS, 32'h07);
    wr(OFS_FLAGS, 32'h00);
    wr(OFS_WORK, 32'h01);
    ex(OP_ADD, 1'b1, 1'b0, 12'h000, 12'h0d8);
    chr("add flags", OFS_FLAGS, 32'h00);
    ex(OP_BSF, 1'b1, 1'b0, 12'h002, 12'h0d8);
    chr("bitset flags", OFS_FLAGS, 32'h04);
    wr(OFS_WORK, 32'h0b);
    ex(OP_MOVE_FROM_WORKING_INSTR, 1'b1, 1'b0, 12'h000, 12'h0d8);
    chr("move_from_working_instr flags", OFS_FLAGS, 32'h0b);
    wr(OFS_OPERAND, 32'h20);
    ex(OP_ADD, 1'b1, 1'b0, 12'h000, 12'h010);
    chr("result", OFS_RESULT, 32'h12b);
    $display("test flag register done");
    wr(OFS_BANK, 32'h3);
    adr(1'b1, 8'h45, 12'h345);
    adr(1'b0, 8'h45, 12'h045);
    adr(1'b0, 8'h80, 12'hf80);
    ex(OP_FULL_ADDRESS_MOVE, 1'b0, 1'b0, 12'h456, 12'h123);
    chr("move addr", OFS_ADDR, 32'h04560123);
    ex(OP_CALL, 1'b0, 1'b0, 12'h0ab, 12'hcde);
    chr("call target", OFS_TARGET, 32'h000abcde);
    ex(OP_GOTO, 1'b0, 1'b0, 12'h012, 12'h345);
    wr(OFS_TARGET, 32'h0);
    chr("goto target", OFS_TARGET, 32'h00012345);
    $display("test addressing done");
    wr(OFS_WORK, 32'hff);
    ind(OFS_PTR0, 12'h0ff, 8'hee, 12'h0ff, 12'h100);
    ind(OFS_PTR0 + 8'h04, 12'h100, 8'he5, 12'h100, 12'h0ff);
    ind(OFS_PTR0, 12'h0ff, 8'hec, 12'h100, 12'h100);
    ind(OFS_PTR0, 12'h0ff, 8'heb, 12'h0fe, 12'h0ff);
    ind(OFS_PTR0, 12'h0ff, 8'hef, 12'h0ff, 12'h0ff);
    chr("working kept", OFS_WORK, 32'hff);
    $display("test indirect done");
    wr(OFS_PTR0 + 8'h08, 32'h200);
    wr(OFS_CTRL, 32'h1);
    adr(1'b0, 8'h10, 12'h210);
    adr(1'b0, 8'h70, 12'hf70);
    adr(1'b1, 8'h10, 12'h310);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", {31'h0, ev}, 32'h1);
    $display("test extended done");
    close_out();
  end
endmodule
`default_nettype wire

// file: verilog/alu_addr_core.sv
// Flag register and data address formation core behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module alu_addr_core
  import alu_addr_pkg::*;
#(
  parameter int ADDR_W = 8 // APB address width
)
(
  input wire logic pclk, // Core clock, 200 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high writes
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data, registered
  output logic pready, // Low during command execution
  output logic pslverr // Unmapped address
);
  // Resolved indirect operand
  typedef struct packed {
    logic hit;
    logic [1:0] idx;
    logic [2:0] kind;
  } ind_t;

  // Whole state of the core
  typedef struct packed {
    phase_t phase; // Idle or executing
    logic [4:0] flags; // Condition flags
    logic [7:0] work; // Working register
    logic [3:0] bank; // Bank select
    logic [PTR_COUNT-1:0][11:0] ptr; // Pointer registers
    logic [7:0] operand; // Stand-in for memory data
    logic ext_en; // Extended set enable
    cmd_t cmd; // Held command
    logic [7:0] result; // Last written value
    logic [11:0] src_addr; // Last source address
    logic [11:0] dst_addr; // Last destination address
    logic dest_file; // Last result went to file
    logic [19:0] target; // Program target
    logic [31:0] rdata; // Read data for APB
  } core_state_t;

  core_state_t st_reg; // Registered state
  core_state_t st_next; // Next state
  cmd_t c; // Command being executed
  ind_t src_ind; // Source indirect decode
  ind_t dst_ind; // Move destination decode
  alu_out_t alu; // ALU answer
  logic [11:0] raw_src; // Source before indirect
  logic [11:0] src_addr; // Effective source
  logic [11:0] wr_addr; // Write-back address
  logic [11:0] ptr_cur; // Selected pointer
  logic [11:0] ptr_new; // Pointer after step
  logic [7:0] fval; // Fetched operand
  logic [4:0] flag_base; // Flags before ALU overlay
  logic is_move; // Full address move
  logic is_jump; // Call or jump
  logic has_d; // Has destination bit
  logic dest_file; // Result goes to file
  logic apb_wr; // Accepted APB write
  logic mapped; // Address decodes

  // Pointer byte address in data space
  function automatic logic [11:0] ptr_lo_addr(input int k);
    ptr_lo_addr = SFR_PTR0_LO - 12'(k * IND_STRIDE);
  endfunction

  // Which pointer and operand kind an address names
  function automatic ind_t find_indirect(input logic [11:0] addr);
    logic [11:0] base;
    find_indirect = '0;
    for (int k = 0; k < PTR_COUNT; k++)
    begin
      base = SFR_IND0 - 12'(k * IND_STRIDE);
      if ((addr <= base) && (addr >= base - IND_SPAN))
      begin
        find_indirect.hit = 1'b1;
        find_indirect.idx = 2'(k);
        find_indirect.kind = 3'(base - addr);
      end
    end
  endfunction

  // Data read: modelled registers, else operand stand-in
  function automatic logic [7:0] read_byte(input core_state_t s, input logic [11:0] addr);
    read_byte = s.operand;
    if (addr == SFR_FLAGS)
      read_byte = {3'b000, s.flags};
    if (addr == SFR_WORK)
      read_byte = s.work;
    if (addr == SFR_BANK)
      read_byte = {4'h0, s.bank};
    for (int k = 0; k < PTR_COUNT; k++)
    begin
      if (addr == ptr_lo_addr(k))
        read_byte = s.ptr[k][7:0];
      if (addr == ptr_lo_addr(k) + 12'h001)
        read_byte = {4'h0, s.ptr[k][11:8]};
    end
  endfunction

  // APB read mux
  function automatic logic [31:0] apb_read(input core_state_t s, input logic [7:0] a);
    apb_read = 32'h0000_0000;
    unique case (a)
      OFS_FLAGS: apb_read = {27'h0, s.flags};
      OFS_WORK: apb_read = {24'h0, s.work};
      OFS_BANK: apb_read = {28'h0, s.bank};
      OFS_OPERAND: apb_read = {24'h0, s.operand};
      OFS_CTRL: apb_read = {31'h0, s.ext_en};
      OFS_CMD: apb_read = s.cmd;
      OFS_RESULT: apb_read = {23'h0, s.dest_file, s.result};
      OFS_ADDR: apb_read = {4'h0, s.dst_addr, 4'h0, s.src_addr};
      OFS_TARGET: apb_read = {12'h0, s.target};
      default:
      begin
        for (int k = 0; k < PTR_COUNT; k++)
        begin
          if (a == OFS_PTR0 + 8'(k * OFS_STEP))
          begin
            apb_read = {20'h0, s.ptr[k]};
          end
        end
      end
    endcase
  endfunction

  // Bus handshake; a command blocks the bus for its execute cycle
  assign pready = (st_reg.phase == ST_IDLE);
  assign prdata = st_reg.rdata;
  assign apb_wr = psel && penable && pwrite && pready;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_W'(OFS_TARGET));
  assign pslverr = psel && penable && pready && !mapped;

  // Command decode
  assign c = st_reg.cmd;
  assign is_move = (c.op == OP_FULL_ADDRESS_MOVE);
  assign is_jump = (c.op == OP_CALL) || (c.op == OP_GOTO);
  assign has_d = (c.op == OP_ADD) || (c.op == OP_SUB) || (c.op == OP_AND)
              || (c.op == OP_MOVF) || (c.op == OP_SWAP) || (c.op == OP_RR)
              || (c.op == OP_RL);
  assign dest_file = has_d ? c.d : !is_jump;

  // Source and destination address formation
  always_comb
  begin
    if (is_move)
      raw_src = c.src;
    else if (c.a)
      raw_src = {st_reg.bank, c.src[7:0]};
    else if (st_reg.ext_en && (c.src[7:0] < ACCESS_SPLIT))
      raw_src = st_reg.ptr[PTR_INDEXED] + {4'h0, c.src[7:0]};
    else
      raw_src = {(c.src[7:0] < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI, c.src[7:0]};
    src_ind = find_indirect(raw_src);
    ptr_cur = st_reg.ptr[src_ind.idx];
    src_addr = raw_src;
    ptr_new = ptr_cur;
    if (src_ind.hit)
    begin
      unique case (src_ind.kind)
        IND_PLAIN: src_addr = ptr_cur;
        IND_POST_INCREMENT_OPERAND:
        begin
          src_addr = ptr_cur;
          ptr_new = ptr_cur + 12'h001;
        end
        IND_POST_DECREMENT_OPERAND:
        begin
          src_addr = ptr_cur;
          ptr_new = ptr_cur - 12'h001;
        end
        IND_PRE_INCREMENT_OPERAND:
        begin
          src_addr = ptr_cur + 12'h001;
          ptr_new = ptr_cur + 12'h001;
        end
        IND_WORKING_OFFSET_OPERAND: src_addr = ptr_cur + {{4{st_reg.work[7]}}, st_reg.work};
        default: src_addr = raw_src;
      endcase
    end
    // Move destination may itself be an indirect operand
    dst_ind = find_indirect(c.dst);
    if (!is_move)
      wr_addr = src_addr;
    else if (dst_ind.hit)
      wr_addr = st_reg.ptr[dst_ind.idx];
    else
      wr_addr = c.dst;
    fval = read_byte(st_reg, src_addr);
  end

  // Arithmetic and flags
  alu_flag_unit u_alu (
    .op(c.op),
    .fval(fval),
    .wval(st_reg.work),
    .bit_sel(c.dst[2:0]),
    .carry_in(st_reg.flags[FLG_C]),
    .res(alu)
  );

  // Next state
  always_comb
  begin
    st_next = st_reg;
    flag_base = st_reg.flags;
    unique case (st_reg.phase)
      ST_IDLE:
      begin
        if (apb_wr)
        begin
          case (paddr[7:0])
            OFS_FLAGS: st_next.flags = pwdata[4:0];
            OFS_WORK: st_next.work = pwdata[7:0];
            OFS_BANK: st_next.bank = pwdata[3:0];
            OFS_OPERAND: st_next.operand = pwdata[7:0];
            OFS_CTRL: st_next.ext_en = pwdata[0];
            OFS_CMD:
            begin
              st_next.cmd = cmd_t'(pwdata);
              st_next.phase = ST_EXEC;
            end
            default: st_next.ext_en = st_reg.ext_en;
          endcase
          for (int k = 0; k < PTR_COUNT; k++)
          begin
            if (paddr[7:0] == OFS_PTR0 + 8'(k * OFS_STEP))
            begin
              st_next.ptr[k] = pwdata[11:0];
            end
          end
        end
      end
      ST_EXEC:
      begin
        st_next.phase = ST_IDLE;
        // pointer step, flags untouched; a jump's literal is no data address
        if (src_ind.hit && !is_jump)
          st_next.ptr[src_ind.idx] = ptr_new;
        st_next.src_addr = src_addr;
        st_next.dst_addr = wr_addr;
        st_next.dest_file = dest_file;
        st_next.result = alu.result;
        if (is_jump)
          st_next.target = {c.dst[7:0], c.src};
        if (dest_file)
        begin
          if ((wr_addr == SFR_FLAGS) && (alu.touched == 5'h00))
            flag_base = alu.result[4:0];
          if (wr_addr == SFR_WORK)
            st_next.work = alu.result;
          if (wr_addr == SFR_BANK)
            st_next.bank = alu.result[3:0];
          for (int k = 0; k < PTR_COUNT; k++)
          begin
            if (wr_addr == ptr_lo_addr(k))
              st_next.ptr[k][7:0] = alu.result;
            if (wr_addr == ptr_lo_addr(k) + 12'h001)
              st_next.ptr[k][11:8] = alu.result[3:0];
          end
        end
        else if (has_d)
          st_next.work = alu.result;
        st_next.flags = (alu.touched & alu.flags) | (~alu.touched & flag_base);
      end
      default: st_next.phase = ST_IDLE;
    endcase
    st_next.rdata = apb_read(st_next, paddr[7:0]);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.phase <= ST_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Checker helpers
  logic exec_now; // Execute cycle
  logic [8:0] chk_sum; // Independent add
  logic [4:0] chk_nib; // Independent nibble add
  logic chk_ov; // Independent overflow
  assign exec_now = (st_reg.phase == ST_EXEC);
  assign chk_sum = {1'b0, fval} + {1'b0, st_reg.work};
  assign chk_nib = {1'b0, fval[3:0]} + {1'b0, st_reg.work[3:0]};
  assign chk_ov = (fval[7] == st_reg.work[7]) && (chk_sum[7] != fval[7]);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_flag_read;
    psel && penable && !pwrite && (paddr == ADDR_W'(OFS_FLAGS));
  endsequence

  sequence s_clr_flags;
    exec_now && (c.op == OP_CLR) && (wr_addr == SFR_FLAGS);
  endsequence

  a_flag_pad_zero: assert property (
    s_flag_read |-> (prdata[31:5] == 27'h0))
    else $error("flag register upper bits not zero");
  a_clr_sets_zero: assert property (
    s_clr_flags |=> st_reg.flags[FLG_Z]
      && ((st_reg.flags & 5'h1b) == ($past(st_reg.flags) & 5'h1b)))
    else $error("clear of flags altered wrong bits");
  a_neg_follows: assert property (
    exec_now && (c.op == OP_AND) |=> st_reg.flags[FLG_N] == $past(fval[7] & st_reg.work[7]))
    else $error("negative flag does not follow bit 7");
  a_zero_follows: assert property (
    exec_now && (c.op == OP_MOVF) |=> st_reg.flags[FLG_Z] == $past(fval == 8'h00))
    else $error("zero flag wrong");
  a_add_overflow: assert property (
    exec_now && (c.op == OP_ADD) |=> st_reg.flags[FLG_OV] == $past(chk_ov))
    else $error("overflow flag wrong after add");
  a_add_carry: assert property (
    exec_now && (c.op == OP_ADD) |=> st_reg.flags[FLG_C] == $past(chk_sum[8]))
    else $error("carry flag wrong after add");
  a_add_nibble: assert property (
    exec_now && (c.op == OP_ADD) |=> st_reg.flags[FLG_DC] == $past(chk_nib[4]))
    else $error("nibble carry wrong after add");
  a_sub_borrow: assert property (
    exec_now && (c.op == OP_SUB) |=> st_reg.flags[FLG_C] == $past(fval >= st_reg.work))
    else $error("borrow polarity wrong after subtract");
  a_rot_nibble: assert property (
    exec_now && (c.op == OP_RR) |=> st_reg.flags[FLG_DC] == $past(fval[4]))
    else $error("rotate right nibble carry wrong");
  a_post_inc: assert property (
    exec_now && src_ind.hit && (src_ind.kind == IND_POST_INCREMENT_OPERAND) && !is_jump
      && (ptr_cur[11:8] != ACCESS_HI)
      |=> st_reg.ptr[$past(src_ind.idx)] == $past(ptr_cur) + 12'h001)
    else $error("post-increment did not step pointer");
  a_flags_hold: assert property (
    !exec_now && !(apb_wr && (paddr == ADDR_W'(OFS_FLAGS))) |=> $stable(st_reg.flags))
    else $error("flags changed without cause");
endmodule
`default_nettype wire

// file: verilog/alu_addr_pkg.sv
// Shared constants and types for the flag and data addressing core
package alu_addr_pkg;
  // APB byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_WORK = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_PTR0 = 8'h0c;
  localparam logic [7:0] OFS_OPERAND = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1c;
  localparam logic [7:0] OFS_CMD = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_ADDR = 8'h28;
  localparam logic [7:0] OFS_TARGET = 8'h2c;
  localparam int OFS_STEP = 4;
  // Flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  // Flags each operation class updates
  localparam logic [4:0] TOUCH_ARITH = 5'h1f;
  localparam logic [4:0] TOUCH_ROT = 5'h17;
  localparam logic [4:0] TOUCH_ZN = 5'h14;
  localparam logic [4:0] TOUCH_Z = 5'h04;
  // Data space addresses of the modelled special registers
  localparam logic [11:0] SFR_FLAGS = 12'hfd8;
  localparam logic [11:0] SFR_WORK = 12'hfe8;
  localparam logic [11:0] SFR_BANK = 12'hfe0;
  localparam logic [11:0] SFR_PTR0_LO = 12'hfe9;
  localparam logic [11:0] SFR_IND0 = 12'hfef;
  localparam logic [11:0] IND_SPAN = 12'h004;
  localparam int IND_STRIDE = 8;
  localparam int PTR_COUNT = 3;
  localparam int PTR_INDEXED = 2;
  // Access bank split and upper page
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI = 4'hf;
  // Indirect operand kinds, distance below the plain operand
  localparam logic [2:0] IND_PLAIN = 3'h0;
  localparam logic [2:0] IND_POST_INCREMENT_OPERAND = 3'h1;
  localparam logic [2:0] IND_POST_DECREMENT_OPERAND = 3'h2;
  localparam logic [2:0] IND_PRE_INCREMENT_OPERAND = 3'h3;
  localparam logic [2:0] IND_WORKING_OFFSET_OPERAND = 3'h4;
  // Operation codes
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_CLR = 4'h2;
  localparam logic [3:0] OP_BCF = 4'h3;
  localparam logic [3:0] OP_BSF = 4'h4;
  localparam logic [3:0] OP_SWAP = 4'h5;
  localparam logic [3:0] OP_MOVE_FROM_WORKING_INSTR = 4'h6;
  localparam logic [3:0] OP_RR = 4'h7;
  localparam logic [3:0] OP_RL = 4'h8;
  localparam logic [3:0] OP_AND = 4'h9;
  localparam logic [3:0] OP_MOVF = 4'ha;
  localparam logic [3:0] OP_FULL_ADDRESS_MOVE = 4'hb;
  localparam logic [3:0] OP_CALL = 4'hc;
  localparam logic [3:0] OP_GOTO = 4'hd;
  // Command word written over APB
  typedef struct packed {
    logic [3:0] op;
    logic d;
    logic a;
    logic [1:0] spare;
    logic [11:0] dst;
    logic [11:0] src;
  } cmd_t;
  // ALU answer
  typedef struct packed {
    logic [7:0] result;
    logic [4:0] flags;
    logic [4:0] touched;
  } alu_out_t;
  // Core phase
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} phase_t;
endpackage

// file: verilog/alu_flag_unit.sv
// Combinational ALU with flag generation
`timescale 1ns/1ps
`default_nettype none
module alu_flag_unit
  import alu_addr_pkg::*;
(
  input wire logic [3:0] op, // Operation code
  input wire logic [7:0] fval, // File operand
  input wire logic [7:0] wval, // Working operand
  input wire logic [2:0] bit_sel, // Bit number for bit ops
  input wire logic carry_in, // Current carry flag
  output alu_out_t res // Result, flags, touched mask
);
  logic [7:0] b_op; // Second adder input
  logic sub_one; // Two's complement increment
  logic [8:0] sum; // Full sum with carry
  logic [4:0] lo_sum; // Low nibble sum

  // Result and flag generation
  always_comb
  begin
    sub_one = (op == OP_SUB);
    b_op = sub_one ? ~wval : wval;
    sum = {1'b0, fval} + {1'b0, b_op} + {8'h00, sub_one};
    lo_sum = {1'b0, fval[3:0]} + {1'b0, b_op[3:0]} + {4'h0, sub_one};
    res = '0;
    unique case (op)
      OP_ADD, OP_SUB:
      begin
        res.result = sum[7:0];
        res.flags[FLG_C] = sum[8];
        res.flags[FLG_DC] = lo_sum[4];
        res.flags[FLG_OV] = (fval[7] == b_op[7]) && (sum[7] != fval[7]);
        res.touched = TOUCH_ARITH;
      end
      OP_CLR:
      begin
        res.result = 8'h00;
        res.touched = TOUCH_Z;
      end
      OP_AND:
      begin
        res.result = fval & wval;
        res.touched = TOUCH_ZN;
      end
      OP_MOVF:
      begin
        res.result = fval;
        res.touched = TOUCH_ZN;
      end
      OP_BCF:
      begin
        res.result = fval & ~(8'h01 << bit_sel);
      end
      OP_BSF:
      begin
        res.result = fval | (8'h01 << bit_sel);
      end
      OP_SWAP:
      begin
        res.result = {fval[3:0], fval[7:4]};
      end
      OP_MOVE_FROM_WORKING_INSTR:
      begin
        res.result = wval;
      end
      OP_RR:
      begin
        res.result = {carry_in, fval[7:1]};
        res.flags[FLG_C] = fval[0];
        res.flags[FLG_DC] = fval[4];
        res.touched = TOUCH_ROT;
      end
      OP_RL:
      begin
        res.result = {fval[6:0], carry_in};
        res.flags[FLG_C] = fval[7];
        res.flags[FLG_DC] = fval[3];
        res.touched = TOUCH_ROT;
      end
      // Moves and jumps pass the operand, no flags
      default:
      begin
        res.result = fval;
      end
    endcase
    res.flags[FLG_N] = res.result[7];
    res.flags[FLG_Z] = (res.result == 8'h00);
  end
endmodule
`default_nettype wire
